// >>> rtl/ice_seq_pkg.sv
package ice_seq_pkg;

  // Clock and timebase figures.
  localparam int CLK_HZ = 20000000;
  localparam int TICK_S = 1;
  localparam int TICK_CYCLES_DEF = CLK_HZ * TICK_S;
  localparam int DEBOUNCE_MS = 20;
  localparam int DEBOUNCE_CYCLES_DEF = (CLK_HZ / 1000) * DEBOUNCE_MS;

  // Sequence delays, in seconds of the shared tick, and the highest purge setting.
  localparam logic [6:0] DRAIN_S = 7'h05;
  localparam logic [6:0] HG_OFF_S = 7'h05;
  localparam logic [6:0] SLUSH_S = 7'h1e;
  localparam logic [6:0] QUAL_AIR_S = 7'h05;
  localparam logic [6:0] QUAL_REMOTE_S = 7'h03;
  localparam logic [6:0] PURGE_DELAY_S = 7'h05;
  localparam logic [6:0] REOPEN_S = 7'h1e;
  localparam logic [6:0] PUMPDOWN_S = 7'h1e;
  localparam logic [6:0] PURGE_AUTO_SOFT_S = 7'h08;
  localparam logic [6:0] PURGE_AUTO_HARD_S = 7'h14;
  localparam logic [6:0] PURGE_STEP_S = 7'h04;
  localparam logic [2:0] PURGE_SET_MAX = 3'h5;

  // Code display values.
  localparam logic [3:0] DISP_BLANK = 4'h0;
  localparam logic [3:0] DISP_OFF = 4'h1;
  localparam logic [3:0] DISP_FREEZE = 4'h2;
  localparam logic [3:0] DISP_HARVEST = 4'h3;
  localparam logic [3:0] DISP_FAIL = 4'h4;

  // Bit positions of the conditioned input vector.
  localparam int IN_ON = 0;
  localparam int IN_MID = 1;
  localparam int IN_TOP = 2;
  localparam int IN_ICE = 3;
  localparam int IN_COLD = 4;
  localparam int IN_HARD = 5;
  localparam int IN_CUR1 = 6;
  localparam int IN_CUR2 = 7;
  localparam int IN_REMOTE = 8;
  localparam int IN_TWO = 9;
  localparam int IN_DONE = 10;
  localparam int IN_PASS = 11;
  localparam int IN_PSET = 12;
  localparam int IN_COUNT = 15;

  typedef enum logic [3:0] {
    ST_CHECK, ST_FAIL, ST_STANDBY, ST_DRAIN, ST_FILL, ST_FREEZE, ST_HARVEST, ST_WAIT, ST_PUMPDOWN
  } seq_state_t;

  typedef struct packed {
    seq_state_t state;
    logic [6:0] cnt;
    logic [2:0] ice_cnt;
    logic [6:0] slush_cnt;
    logic slush_on;
    logic slush_done;
    logic hard;
    logic seen1;
    logic seen2;
    logic on_armed;
    logic comp;
    logic llv;
    logic fan;
    logic pump;
    logic purge;
    logic inlet;
    logic hg;
    logic assist;
    logic [3:0] disp;
    logic blink;
    logic power_led;
    logic status_led;
    logic empty_led;
    logic full_led;
    logic cur1_led;
    logic cur2_led;
    logic ready_led;
  } seq_t;

  // Everything off, sequencer in self check (ST_CHECK encodes as zero).
  localparam seq_t SEQ_RESET = '0;

endpackage

// >>> rtl/input_conditioner.sv
`timescale 1ns/100ps
`default_nettype none
module input_conditioner #(
  parameter int WIDTH = 15,
  parameter int DEB_CYCLES = 400000
) (
  input wire logic clk_i,               // System clock.
  input wire logic rst_i,               // Synchronous reset, active high.
  input wire logic [WIDTH-1:0] raw_i,   // Asynchronous switch and probe levels.
  output logic [WIDTH-1:0] clean_o      // Synchronised, debounced levels.
);
  localparam int CW = $clog2(DEB_CYCLES + 1);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] samp_reg;
  logic [WIDTH-1:0] clean_reg;
  logic [CW-1:0] div_reg;
  logic strobe;

  if (DEB_CYCLES < 1 || WIDTH < 1) begin : g_chk
    $error("input_conditioner needs DEB_CYCLES and WIDTH of at least one.");
  end

  assign strobe = (div_reg == CW'(DEB_CYCLES - 1));
  assign clean_o = clean_reg;

  // Two flops against metastability, then a bit changes only when two samples one period apart agree.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
      samp_reg <= '0;
      clean_reg <= '0;
      div_reg <= '0;
    end else begin
      meta_reg <= raw_i;
      sync_reg <= meta_reg;
      div_reg <= strobe ? '0 : div_reg + CW'(1);
      if (strobe) begin
        samp_reg <= sync_reg;
        clean_reg <= (sync_reg & samp_reg) | (clean_reg & (sync_reg | samp_reg));
      end
    end
  end
endmodule
`default_nettype wire

// >>> rtl/seconds_timebase.sv
`timescale 1ns/100ps
`default_nettype none
module seconds_timebase #(
  parameter int TICK_CYCLES = 20000000
) (
  input wire logic clk_i,   // System clock.
  input wire logic rst_i,   // Synchronous reset, active high.
  output logic tick_o       // One-cycle pulse once per second.
);
  localparam int CW = $clog2(TICK_CYCLES + 1);

  logic [CW-1:0] cnt_reg;
  logic tick_reg;

  if (TICK_CYCLES < 2) begin : g_chk
    $error("seconds_timebase needs TICK_CYCLES of at least two.");
  end

  assign tick_o = tick_reg;

  // Free-running divider; the pulse marks the wrap.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= (cnt_reg == CW'(TICK_CYCLES - 1));
      cnt_reg <= (cnt_reg == CW'(TICK_CYCLES - 1)) ? '0 : cnt_reg + CW'(1);
    end
  end
endmodule
`default_nettype wire

// >>> rtl/ice_cuber_cycle_sequencer.sv
// Overview of operation
// - Failed self check shows error, stays inert.
// - Passed check: off code, lights, standby.
// - On press-release starts; freeze code blinks.
// - Startup drains with hot gas, then stops.
// - Inlet opens when mid uncovered, closes full.
// - Full reservoir starts compressor, pump, fan (air) or line valve (remote).
// - Hot gas off five seconds into freeze.
// - Freeze shows steady code and green lights.
// - Cold water pauses pump thirty seconds.
// - Pause samples conductivity for auto purge.
// - Air/water: five seconds steady ice contact.
// - Remote: three seconds steady ice contact.
// - Air/water harvest: fan off, hot gas on.
// - Delayed purge and pump for purge time.
// - Harvest ends when the curtain(s) open.
// - Harvest end drops hot gas and assist.
// - Curtain reclosing within thirty seconds refreezes.
// - Remote shutdown pumps down thirty seconds.
// - Curtain open thirty seconds means bin full.
// - Mid and top probes decode empty and full.
`timescale 1ns/100ps
`default_nettype none
module ice_cuber_cycle_sequencer
  import ice_seq_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF,
  parameter int DEB_CYCLES = DEBOUNCE_CYCLES_DEF
) (
  input wire logic clk_i,              // System clock, 20 MHz.
  input wire logic rst_i,              // Synchronous reset, active high.
  input wire logic on_btn_i,           // On pushbutton, high while pressed.
  input wire logic mid_probe_i,        // High while the mid probe touches water.
  input wire logic top_probe_i,        // High while the top probe touches water.
  input wire logic ice_probe_i,        // High while water touches the ice thickness probe.
  input wire logic water_cold_i,       // High when water is at the low threshold.
  input wire logic water_hard_i,       // High when reservoir conductivity is high.
  input wire logic curtain1_closed_i,  // High while curtain one is closed.
  input wire logic curtain2_closed_i,  // High while curtain two is closed.
  input wire logic remote_cfg_i,       // High on remote-condenser machines.
  input wire logic two_evap_cfg_i,     // High on two-evaporator machines.
  input wire logic selftest_done_i,    // High once the self check has finished.
  input wire logic selftest_pass_i,    // High when the self check found no fault.
  input wire logic [2:0] purge_set_i,  // Purge setting, zero for automatic.
  output logic compressor_o,           // Compressor contactor.
  output logic liquid_valve_o,         // Liquid line valve.
  output logic fan_o,                  // Condenser fan.
  output logic pump_o,                 // Water pump.
  output logic purge_o,                // Purge valve.
  output logic inlet_o,                // Inlet water valve.
  output logic hot_gas_o,              // Hot gas valve.
  output logic assist_o,               // Harvest assist solenoid.
  output logic [3:0] disp_code_o,      // Code display value.
  output logic disp_blink_o,           // Code display blinks.
  output logic power_led_o,            // Power light.
  output logic status_led_o,           // Status light, green.
  output logic sump_empty_led_o,       // Sump empty light.
  output logic sump_full_led_o,        // Sump full light.
  output logic curtain1_led_o,         // Curtain one closed light.
  output logic curtain2_led_o,         // Curtain two closed light.
  output logic ready_led_o             // Ready to harvest light.
);

  logic [IN_COUNT-1:0] raw;
  logic [IN_COUNT-1:0] in_q;
  logic tick;
  seq_t s_reg;
  seq_t s_next;
  logic mid;
  logic top;
  logic ice;
  logic cur1;
  logic cur2;
  logic remote;
  logic two;
  logic closed_all;
  logic harvest_done;
  logic [6:0] qual;
  logic [6:0] ptime;
  logic [6:0] pend;

  // Purge run time from the setting; zero selects the time chosen from conductivity.
  function automatic logic [6:0] purge_secs(input logic [2:0] set, input logic hard);
    logic [2:0] lim;
    lim = (set > PURGE_SET_MAX) ? PURGE_SET_MAX : set;
    if (set == 3'h0) begin
      return hard ? PURGE_AUTO_HARD_S : PURGE_AUTO_SOFT_S;
    end
    return 7'({4'h0, lim} * PURGE_STEP_S);
  endfunction

  // Gather every external level for synchronising and debouncing.
  assign raw = {purge_set_i, selftest_pass_i, selftest_done_i, two_evap_cfg_i, remote_cfg_i,
                curtain2_closed_i, curtain1_closed_i, water_hard_i, water_cold_i, ice_probe_i,
                top_probe_i, mid_probe_i, on_btn_i};

  input_conditioner #(
    .WIDTH(IN_COUNT),
    .DEB_CYCLES(DEB_CYCLES)
  ) u_cond (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .raw_i(raw),
    .clean_o(in_q)
  );

  seconds_timebase #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_o(tick)
  );

  // Decoded conditions used by the sequence.
  assign mid = in_q[IN_MID];
  assign top = in_q[IN_TOP];
  assign ice = in_q[IN_ICE];
  assign cur1 = in_q[IN_CUR1];
  assign cur2 = in_q[IN_CUR2];
  assign remote = in_q[IN_REMOTE];
  assign two = in_q[IN_TWO];
  assign closed_all = cur1 & (cur2 | ~two);
  assign qual = remote ? QUAL_REMOTE_S : QUAL_AIR_S;
  assign ptime = purge_secs(in_q[IN_PSET +: 3], s_reg.hard);
  assign pend = 7'(PURGE_DELAY_S + ptime);
  assign harvest_done = two ? ((s_reg.seen1 | ~cur1) & (s_reg.seen2 | ~cur2)) : ~cur1;

  // Next state of the whole sequencer.
  always_comb begin
    s_next = s_reg;
    if (tick && s_reg.cnt != 7'h7f) begin
      s_next.cnt = s_reg.cnt + 7'h01;
    end
    case (s_reg.state)
      ST_CHECK: begin
        if (in_q[IN_DONE]) begin
          s_next.state = in_q[IN_PASS] ? ST_STANDBY : ST_FAIL;
        end
      end
      ST_FAIL: begin
        s_next.state = ST_FAIL;
      end
      ST_STANDBY: begin
        if (in_q[IN_ON]) begin
          s_next.on_armed = 1'b1;
        end else if (s_reg.on_armed) begin
          // Release after a press starts the drain with hot gas and assist energised.
          s_next.on_armed = 1'b0;
          s_next.state = ST_DRAIN;
          s_next.cnt = 7'h00;
          s_next.purge = 1'b1;
          s_next.pump = 1'b1;
          s_next.hg = 1'b1;
          s_next.assist = 1'b1;
        end
      end
      ST_DRAIN: begin
        if (s_reg.cnt >= DRAIN_S) begin
          s_next.purge = 1'b0;
          s_next.pump = 1'b0;
          s_next.state = ST_FILL;
          s_next.cnt = 7'h00;
        end
      end
      ST_FILL: begin
        if (top) begin
          s_next.state = ST_FREEZE;
          s_next.cnt = 7'h00;
          s_next.comp = 1'b1;
          s_next.pump = 1'b1;
          s_next.llv = remote;
          s_next.fan = ~remote;
          s_next.ice_cnt = 3'h0;
          s_next.slush_on = 1'b0;
          s_next.slush_done = 1'b0;
        end
      end
      ST_FREEZE: begin
        if (s_reg.cnt >= HG_OFF_S) begin
          s_next.hg = 1'b0;
          s_next.assist = 1'b0;
        end
        // One anti-slush pause per freeze; the conductivity sample is taken as it begins.
        if (in_q[IN_COLD] && !s_reg.slush_on && !s_reg.slush_done) begin
          s_next.slush_on = 1'b1;
          s_next.slush_cnt = 7'h00;
          s_next.pump = 1'b0;
          s_next.hard = in_q[IN_HARD];
        end
        if (s_reg.slush_on) begin
          if (tick) begin
            s_next.slush_cnt = s_reg.slush_cnt + 7'h01;
          end
          if (s_reg.slush_cnt >= SLUSH_S) begin
            s_next.slush_on = 1'b0;
            s_next.slush_done = 1'b1;
            s_next.pump = 1'b1;
          end
        end
        // Any break in contact restarts the qualification count.
        if (!ice) begin
          s_next.ice_cnt = 3'h0;
        end else if (tick && s_reg.ice_cnt != 3'h7) begin
          s_next.ice_cnt = s_reg.ice_cnt + 3'h1;
        end
        if (ice && {4'h0, s_reg.ice_cnt} >= qual) begin
          s_next.state = ST_HARVEST;
          s_next.cnt = 7'h00;
          s_next.fan = 1'b0;
          s_next.hg = 1'b1;
          s_next.assist = 1'b1;
          s_next.pump = 1'b0;
          s_next.slush_on = 1'b0;
          s_next.seen1 = 1'b0;
          s_next.seen2 = 1'b0;
        end
      end
      ST_HARVEST: begin
        s_next.pump = (s_reg.cnt >= PURGE_DELAY_S) && (s_reg.cnt < pend);
        s_next.purge = (s_reg.cnt >= PURGE_DELAY_S) && (s_reg.cnt < pend);
        s_next.seen1 = s_reg.seen1 | ~cur1;
        s_next.seen2 = s_reg.seen2 | ~cur2;
        if (harvest_done) begin
          s_next.state = ST_WAIT;
          s_next.cnt = 7'h00;
          s_next.hg = 1'b0;
          s_next.assist = 1'b0;
          s_next.pump = 1'b0;
          s_next.purge = 1'b0;
        end
      end
      ST_WAIT: begin
        if (closed_all) begin
          s_next.state = ST_FILL;
          s_next.cnt = 7'h00;
        end else if (s_reg.cnt >= REOPEN_S) begin
          // A curtain held open means bin full; remote units pump down first.
          s_next.cnt = 7'h00;
          s_next.llv = 1'b0;
          s_next.fan = 1'b0;
          if (remote) begin
            s_next.state = ST_PUMPDOWN;
          end else begin
            s_next.state = ST_STANDBY;
            s_next.comp = 1'b0;
          end
        end
      end
      ST_PUMPDOWN: begin
        if (s_reg.cnt >= PUMPDOWN_S) begin
          s_next.state = ST_STANDBY;
          s_next.comp = 1'b0;
        end
      end
      default: begin
        s_next = SEQ_RESET;
      end
    endcase
    // Refill may happen in any running state.
    if (s_next.state == ST_CHECK || s_next.state == ST_FAIL) begin
      s_next.inlet = 1'b0;
    end else if (!mid) begin
      s_next.inlet = 1'b1;
    end else if (top) begin
      s_next.inlet = 1'b0;
    end
    // Display and indicator lights follow the next state.
    case (s_next.state)
      ST_CHECK: s_next.disp = DISP_BLANK;
      ST_FAIL: s_next.disp = DISP_FAIL;
      ST_STANDBY: s_next.disp = DISP_OFF;
      ST_DRAIN, ST_FILL, ST_FREEZE: s_next.disp = DISP_FREEZE;
      ST_HARVEST: s_next.disp = DISP_HARVEST;
      default: s_next.disp = DISP_OFF;
    endcase
    s_next.blink = (s_next.state == ST_DRAIN) || (s_next.state == ST_FILL);
    s_next.power_led = (s_next.state != ST_CHECK) && (s_next.state != ST_FAIL);
    s_next.status_led = (s_next.state == ST_FREEZE) || (s_next.state == ST_HARVEST);
    s_next.empty_led = s_next.power_led && !mid;
    s_next.full_led = s_next.power_led && top;
    s_next.cur1_led = s_next.power_led && cur1;
    s_next.cur2_led = s_next.power_led && two && cur2;
    s_next.ready_led = s_next.power_led && ice;
  end

  // Single state register; reset drops every load.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= SEQ_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register.
  assign compressor_o = s_reg.comp;
  assign liquid_valve_o = s_reg.llv;
  assign fan_o = s_reg.fan;
  assign pump_o = s_reg.pump;
  assign purge_o = s_reg.purge;
  assign inlet_o = s_reg.inlet;
  assign hot_gas_o = s_reg.hg;
  assign assist_o = s_reg.assist;
  assign disp_code_o = s_reg.disp;
  assign disp_blink_o = s_reg.blink;
  assign power_led_o = s_reg.power_led;
  assign status_led_o = s_reg.status_led;
  assign sump_empty_led_o = s_reg.empty_led;
  assign sump_full_led_o = s_reg.full_led;
  assign curtain1_led_o = s_reg.cur1_led;
  assign curtain2_led_o = s_reg.cur2_led;
  assign ready_led_o = s_reg.ready_led;

  // Checks on the sequence.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence enter_freeze_s;
    (s_reg.state != ST_FREEZE) ##1 (s_reg.state == ST_FREEZE);
  endsequence

  sequence leave_harvest_s;
    (s_reg.state == ST_HARVEST) ##1 (s_reg.state != ST_HARVEST);
  endsequence

  fail_inert_a: assert property ((s_reg.state == ST_FAIL) |-> (disp_code_o == DISP_FAIL) &&
    !compressor_o && !pump_o && !inlet_o && !hot_gas_o && !purge_o && !fan_o)
    else $error("Loads active after a failed self check.");
  standby_show_a: assert property ((s_reg.state == ST_STANDBY) |-> (disp_code_o == DISP_OFF) &&
    power_led_o && (sump_empty_led_o == !$past(mid)))
    else $error("Standby display or lights wrong.");
  start_blink_a: assert property ((s_reg.state == ST_DRAIN) |-> disp_blink_o &&
    (disp_code_o == DISP_FREEZE))
    else $error("Startup does not blink the freeze code.");
  drain_loads_a: assert property ($rose(s_reg.state == ST_DRAIN) |-> purge_o && pump_o &&
    hot_gas_o && assist_o)
    else $error("Drain loads not energised.");
  inlet_low_a: assert property ((s_reg.state != ST_CHECK && s_reg.state != ST_FAIL && !mid)
    ##1 (s_reg.state != ST_FAIL) |-> inlet_o)
    else $error("Inlet valve closed while water is low.");
  freeze_start_a: assert property (enter_freeze_s |-> compressor_o && pump_o &&
    (liquid_valve_o == remote) && !inlet_o)
    else $error("Freeze started without its loads.");
  hg_release_a: assert property ((s_reg.state == ST_FREEZE && s_reg.cnt > HG_OFF_S) |->
    !hot_gas_o && !assist_o)
    else $error("Hot gas still on well into freeze.");
  freeze_lights_a: assert property ((s_reg.state == ST_FREEZE) |-> status_led_o &&
    power_led_o && !disp_blink_o)
    else $error("Freeze lights wrong.");
  slush_pause_a: assert property (s_reg.slush_on |-> !pump_o && (s_reg.slush_cnt <= SLUSH_S))
    else $error("Pump running during the anti-slush pause.");
  harvest_entry_a: assert property ($rose(s_reg.state == ST_HARVEST) |->
    $past(s_reg.ice_cnt) >= qual[2:0] && $past(ice))
    else $error("Harvest entered without qualified ice contact.");
  harvest_fan_a: assert property ((s_reg.state == ST_HARVEST && !remote) |-> !fan_o &&
    hot_gas_o && assist_o)
    else $error("Fan on or hot gas off during harvest.");
  purge_window_a: assert property ((s_reg.state == ST_HARVEST) ##1 (s_reg.state == ST_HARVEST)
    |-> purge_o == ($past(s_reg.cnt) >= PURGE_DELAY_S && $past(s_reg.cnt) < $past(pend)))
    else $error("Purge outside its window.");
  harvest_end_a: assert property (leave_harvest_s |-> !hot_gas_o && !assist_o &&
    (s_reg.state == ST_WAIT))
    else $error("Hot gas or assist left on after harvest.");
  reopen_limit_a: assert property ((s_reg.state == ST_WAIT) |-> s_reg.cnt <= REOPEN_S)
    else $error("Curtain wait ran past its limit.");
  pumpdown_a: assert property ((s_reg.state == ST_PUMPDOWN) |-> compressor_o &&
    !liquid_valve_o && s_reg.cnt <= PUMPDOWN_S)
    else $error("Pump-down loads wrong.");
  reset_off_a: assert property (@(posedge clk_i) disable iff (1'b0) rst_i |=>
    !compressor_o && !pump_o && !hot_gas_o && !inlet_o && (s_reg.state == ST_CHECK))
    else $error("Loads not dropped by reset.");

endmodule
`default_nettype wire

// >>> tb/sump_model.sv
`timescale 1ns/100ps
`default_nettype none
module sump_model (
  input wire logic clk_i,   // System clock.
  input wire logic inlet_i, // Inlet valve open.
  input wire logic drain_i, // Pump and purge both on.
  output logic mid_o,       // Mid probe wet.
  output logic top_o        // Top probe wet.
);
  int lvl = 3;
  int div = 0;
  // The level moves one step every eight cycles, so fills and drains take time.
  always @(posedge clk_i) begin
    div <= (div + 1) % 8;
    if (div == 0) begin
      lvl <= lvl + (inlet_i ? 1 : 0) - ((drain_i && lvl > 0) ? 1 : 0);
    end
  end
  // Mid probe means refill needed when dry, top probe means full.
  assign mid_o = lvl >= 2;
  assign top_o = lvl >= 6;
endmodule
`default_nettype wire

// >>> tb/ice_cuber_cycle_sequencer_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module ice_cuber_cycle_sequencer_tb_top;
  import ice_seq_pkg::*;
  localparam int TK = 20;
  typedef struct {logic r; logic t; logic h; logic rc; logic el; logic ef;} row_t;
  row_t rows[4] = '{'{0, 0, 0, 1, 0, 1}, '{1, 1, 1, 0, 1, 0}, '{0, 1, 0, 0, 0, 1}, '{1, 0, 0, 1, 1, 0}};
  logic clk_i = 0, rst_i = 1, on_b = 0, ice = 0, cold = 0, hard = 0;
  logic c1 = 1, c2 = 1, rem = 0, two = 0, done = 0, pass = 0;
  logic [2:0] pset = 3'h3;
  wire mid, top, blink, pwr, stat;
  wire [3:0] disp;
  wire [7:0] ld;
  int err_count = 0, n_compared = 0, cyc = 0, q;

  ice_cuber_cycle_sequencer #(.TICK_CYCLES(TK), .DEB_CYCLES(2)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .on_btn_i(on_b), .mid_probe_i(mid), .top_probe_i(top),
    .ice_probe_i(ice), .water_cold_i(cold), .water_hard_i(hard), .curtain1_closed_i(c1),
    .curtain2_closed_i(c2), .remote_cfg_i(rem), .two_evap_cfg_i(two), .selftest_done_i(done),
    .selftest_pass_i(pass), .purge_set_i(pset), .compressor_o(ld[7]), .liquid_valve_o(ld[6]),
    .fan_o(ld[5]), .pump_o(ld[4]), .purge_o(ld[3]), .inlet_o(ld[2]), .hot_gas_o(ld[1]),
    .assist_o(ld[0]), .disp_code_o(disp), .disp_blink_o(blink), .power_led_o(pwr),
    .status_led_o(stat), .sump_empty_led_o(), .sump_full_led_o(), .curtain1_led_o(),
    .curtain2_led_o(), .ready_led_o());

  sump_model i_sump (.clk_i(clk_i), .inlet_i(ld[2]), .drain_i(ld[4] & ld[3]), .mid_o(mid), .top_o(top));

  // Clock and a cycle ceiling that cuts a hang short.
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      stop_test();
    end
  end

  // Shared comparison, waits and closing report.
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tk(input int n);
    repeat (n * TK) @(negedge clk_i);
  endtask
  task automatic wl(input int b, input logic v, input int n);
    for (int i = 0; i < n * TK && ld[b] !== v; i++) @(negedge clk_i);
  endtask
  task automatic wd(input logic [3:0] c, input int n);
    for (int i = 0; i < n * TK && disp !== c; i++) @(negedge clk_i);
  endtask
  task automatic boot(input logic p);
    @(posedge clk_i);
    rst_i <= 1;
    done <= 0;
    c1 <= 1;
    c2 <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    done <= 1;
    pass <= p;
    @(negedge clk_i);
    chk("loads after reset", 8'h00, ld);
    tk(1);
    chk("check display", p ? DISP_OFF : DISP_FAIL, disp);
    chk("power light", p, pwr);
  endtask
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Failed self check, then one full ice cycle for each configuration row.
  initial begin
    boot(0);
    tk(3);
    chk("inert after failure", 8'h00, ld);
    $display("self check test done");
    foreach (rows[k]) begin
      @(posedge clk_i) begin
        rem <= rows[k].r;
        two <= rows[k].t;
        hard <= rows[k].h;
        pset <= (k == 0) ? 3'h3 : 3'h0;
      end
      boot(1);
      @(posedge clk_i) on_b <= 1;
      tk(1);
      @(posedge clk_i) on_b <= 0;
      wd(DISP_FREEZE, 1);
      chk("blink", 1, blink);
      chk("drain loads", 8'h1b, ld & 8'h9b);
      wl(2, 1, 8);
      chk("inlet on", 1, ld[2]);
      wl(7, 1, 20);
      chk("freeze loads", {1'b1, rows[k].el, rows[k].ef, 5'h13}, ld);
      tk(HG_OFF_S - 2);
      chk("hot gas held", 3, ld[1:0]);
      tk(4);
      chk("hot gas off", 0, ld[1:0]);
      chk("freeze display", {4'h3, DISP_FREEZE}, {1'b0, blink, stat, pwr, disp});
      @(posedge clk_i) cold <= 1;
      tk(1);
      chk("pump paused", 0, ld[4]);
      @(posedge clk_i) cold <= 0;
      tk(SLUSH_S - 4);
      chk("pump still paused", 0, ld[4]);
      tk(6);
      chk("pump resumed", 1, ld[4]);
      q = rows[k].r ? QUAL_REMOTE_S : QUAL_AIR_S;
      @(posedge clk_i) ice <= 1;
      tk(q - 2);
      @(posedge clk_i) ice <= 0;
      tk(1);
      @(posedge clk_i) ice <= 1;
      tk(q - 2);
      chk("short contact", DISP_FREEZE, disp);
      wd(DISP_HARVEST, 4);
      chk("harvest loads", 8'h83, ld & 8'hbb);
      @(posedge clk_i) ice <= 0;
      tk(PURGE_DELAY_S + 2);
      chk("purge running", 8'h18, ld & 8'h18);
      chk("fan held off", 0, ld[5]);
      @(posedge clk_i) c1 <= 0;
      tk(2);
      chk("one curtain open", {rows[k].t, rows[k].t}, ld[1:0]);
      @(posedge clk_i) c2 <= 0;
      tk(2);
      chk("harvest over", 0, ld[1:0]);
      if (rows[k].rc) begin
        @(posedge clk_i) begin
          c1 <= 1;
          c2 <= 1;
        end
        wd(DISP_FREEZE, 20);
        for (int i = 0; i < 20 * TK && stat !== 1'b1; i++) @(negedge clk_i);
        chk("refreeze", {2'h3, DISP_FREEZE}, {ld[7], stat, disp});
      end else begin
        tk(REOPEN_S + 2);
        chk("shutdown loads", {rows[k].r, 7'h0}, ld & 8'hf0);
        tk(PUMPDOWN_S + 2);
        chk("stopped", {4'h0, DISP_OFF}, {ld[7:4], disp});
      end
      $display("cycle test %0d done", k);
    end
    stop_test();
  end
endmodule
`default_nettype wire
